// ===== hdl/sltsi_fifo.sv
/*
 Synchronous FIFO with valid/ready on both sides.
 Assumes one clock and an asynchronous active-low reset.
*/
module sltsi_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // ==========================================================
  // Flags from the fill count
  // Full only when the count reaches the depth; the count is one bit wider than pointers
  assign in_ready = cnt_reg < (AW+1)'(DEPTH);
  assign out_valid = cnt_reg != '0;
  assign out_data = mem[rd_reg];

  // Storage has no reset; only pointers and fill count do
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wr_reg <= AW'(wr_reg + 1'b1);
      if (pop) rd_reg <= AW'(rd_reg + 1'b1);
      cnt_reg <= (AW+1)'(cnt_reg + push - pop);
    end
  end
endmodule // sltsi_fifo

// ===== hdl/sltsi_pkg.sv
/*
 Shared constants, types and the register map for the sample LSB
 timestamp marker inserter.
 Assumes a single pclk domain and a 32-bit APB register bus.
*/
package sltsi_pkg;
  // ==========================================================
  // Register map
  localparam logic [11:0] SLTSI_ADDR_LSB_CTRL = 12'h160;
  localparam logic [11:0] SLTSI_ADDR_CONFIG = 12'h164;
  localparam logic [11:0] SLTSI_ADDR_STATUS = 12'h168;
  localparam logic [7:0] SLTSI_LSB_CTRL_RESET = 8'h00;
  localparam logic [7:0] SLTSI_CONFIG_RESET = 8'h00;
  localparam int SLTSI_TS_EN_BIT = 0;
  localparam int SLTSI_CAL_EN_BIT = 0;
  localparam int SLTSI_MODE8_BIT = 1;
  localparam int SLTSI_BYPASS_BIT = 2;
  localparam int SLTSI_RECV_BIT = 3;
  // ==========================================================
  // Sample format and pipeline
  localparam int SLTSI_SAMPLE_W = 12;
  localparam int SLTSI_FIFO_DEPTH = 32;
  localparam int SLTSI_FIFO_AW = 5;
  localparam logic [3:0] SLTSI_ILA_CS = 4'h0;

  typedef enum logic [1:0] {
    SLTSI_LSB_DATA,
    SLTSI_LSB_MARK,
    SLTSI_LSB_CAL
  } sltsi_lsb_e;

  typedef struct packed {
    logic [SLTSI_SAMPLE_W-1:0] data;
    logic marker;
  } sltsi_sample_s;
endpackage

// ===== hdl/sltsi_top.sv
/*
 Sample LSB timestamp marker inserter: replaces the sample LSB with
 the timestamp marker (or calibration flag) ahead of the link layer.
 Assumes samples and markers arrive aligned in the same cycle, and
 an APB master on pclk.
*/
// The APB register port is this design's own decision.
module sltsi_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic s_valid,
  output logic s_ready,
  input wire logic [sltsi_pkg::SLTSI_SAMPLE_W-1:0] s_data,
  input wire logic s_marker,
  input wire logic s_cal_state,
  output logic m_valid,
  input wire logic m_ready,
  output logic [sltsi_pkg::SLTSI_SAMPLE_W-1:0] m_data,
  output logic [3:0] ila_cs,
  output logic marker_receiver_enable
);
  localparam int W = sltsi_pkg::SLTSI_SAMPLE_W;
  logic [7:0] lsb_ctrl_reg;
  logic [7:0] config_reg;
  logic [W-1:0] out_reg;
  logic out_valid_reg;
  sltsi_pkg::sltsi_sample_s fifo_in;
  sltsi_pkg::sltsi_sample_s fifo_out;
  logic fifo_valid;
  logic fifo_ready;

  // ==========================================================
  // APB decode
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire hit_ctrl = paddr == sltsi_pkg::SLTSI_ADDR_LSB_CTRL;
  wire hit_cfg = paddr == sltsi_pkg::SLTSI_ADDR_CONFIG;
  wire hit_stat = paddr == sltsi_pkg::SLTSI_ADDR_STATUS;
  wire mapped = hit_ctrl || hit_cfg || hit_stat;
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;

  // Register writes; reserved bits read back as written
  // Reset to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lsb_ctrl_reg <= sltsi_pkg::SLTSI_LSB_CTRL_RESET;
      config_reg <= sltsi_pkg::SLTSI_CONFIG_RESET;
    end else begin
      if (wr && hit_ctrl) lsb_ctrl_reg <= pwdata[7:0];
      if (wr && hit_cfg) config_reg <= pwdata[7:0];
    end
  end

  // Read mux; status shows effective selection and pipeline state
  wire ts_en = lsb_ctrl_reg[sltsi_pkg::SLTSI_TS_EN_BIT];
  wire cal_en = config_reg[sltsi_pkg::SLTSI_CAL_EN_BIT];
  wire mode8 = config_reg[sltsi_pkg::SLTSI_MODE8_BIT];
  wire bypass = config_reg[sltsi_pkg::SLTSI_BYPASS_BIT];
  assign marker_receiver_enable = config_reg[sltsi_pkg::SLTSI_RECV_BIT];
  wire ts_active = ts_en && bypass;
  wire cal_active = cal_en && !ts_active;
  sltsi_pkg::sltsi_lsb_e sel;
  assign sel = ts_active ? sltsi_pkg::SLTSI_LSB_MARK :
               cal_active ? sltsi_pkg::SLTSI_LSB_CAL : sltsi_pkg::SLTSI_LSB_DATA;
  wire [31:0] stat_word = {28'h0000000, fifo_valid, out_valid_reg, sel};
  assign prdata = !(acc && !pwrite) ? 32'h00000000 :
                  hit_ctrl ? {24'h000000, lsb_ctrl_reg} :
                  hit_cfg ? {24'h000000, config_reg} :
                  hit_stat ? stat_word : 32'h00000000;

  // ==========================================================
  // Sample path: marker rides with its sample through the FIFO
  // Same latency
  assign fifo_in.data = s_data;
  assign fifo_in.marker = ts_active ? s_marker : s_cal_state;

  sltsi_fifo #(
    .WIDTH(W + 1),
    .DEPTH(sltsi_pkg::SLTSI_FIFO_DEPTH),
    .AW(sltsi_pkg::SLTSI_FIFO_AW)
  ) u_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .in_valid(s_valid),
    .in_ready(s_ready),
    .in_data(fifo_in),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready),
    .out_data(fifo_out)
  );

  // LSB position depends on 8-bit or 12-bit sample width
  function automatic logic [W-1:0] insert_lsb(input logic [W-1:0] d,
                                              input logic b, input logic m8);
    logic [W-1:0] r;
    r = d;
    if (m8) begin
      r[W-8] = b;
    end else begin
      r[0] = b;
    end
    return r;
  endfunction

  wire keep_bit = sel != sltsi_pkg::SLTSI_LSB_DATA;
  wire [W-1:0] shaped = keep_bit ? insert_lsb(fifo_out.data, fifo_out.marker, mode8)
                                 : fifo_out.data;
  // Output stage drains when empty or taken
  assign fifo_ready = !out_valid_reg || m_ready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_reg <= '0;
      out_valid_reg <= 1'b0;
    end else if (fifo_ready) begin
      out_reg <= shaped;
      out_valid_reg <= fifo_valid;
    end
  end
  assign m_valid = out_valid_reg;
  assign m_data = out_reg;

  assign ila_cs = sltsi_pkg::SLTSI_ILA_CS;
endmodule // sltsi_top

// ===== testbench/sample_lsb_timestamp_insert_tb.sv
/* Bench: APB setup, random sample stream, queue model.
 Assumes the checker binds itself. */
module sample_lsb_timestamp_insert_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, s_valid, s_marker, s_cal_state;
  logic pready, pslverr, s_ready, m_valid, m_ready, err, marker_receiver_enable;
  logic [11:0] paddr, s_data, m_data, e, msk;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] ila_cs;
  logic [1:0] style;
  logic [4:0] md;
  logic [13:0] r, q[$];
  int bad_count, n_checks, k;
  const logic [4:0] MODES[6] = '{5'h00, 5'h1C, 5'h01, 5'h1D, 5'h10, 5'h1E};
  sltsi_top i_sltsi_top (.*);
  sltsi_link_model i_sltsi_link_model (.clk(pclk), .style(style), .m_ready(m_ready));
  // ====
  // Clock and watchdog
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    #50000;
    bad_count++;
    report_and_stop();
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
      bad_count++;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // model of output LSB, settings read at output
  assign msk = md[1] ? 12'hFF0 : 12'hFFF;
  always @(posedge pclk) begin
    if (s_valid && s_ready) q.push_back({s_cal_state, s_marker, s_data});
    if (m_valid && m_ready && q.size() > 0) begin
      r = q.pop_front();
      e = r[11:0];
      if (md[4] && md[2]) e[md[1] ? 4 : 0] = r[12];
      else if (md[0]) e[md[1] ? 4 : 0] = r[13];
      chk({20'h0, m_data & msk}, {20'h0, e & msk});
    end
  end
  // ====
  // Main sequence
  initial begin
    void'($urandom(11));
    {psel, penable, pwrite, s_valid, s_marker, s_cal_state} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    s_data = 12'h000;
    style = 2'h2;
    md = 5'h00;
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h160, 0);
    chk(rd, 32'h0);
    apb(0, 12'h000, 0);
    chk({31'h0, err}, 32'h1);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      md = MODES[i];
      apb(1, 12'h160, {31'h0, md[4]});
      apb(1, 12'h164, {28'h0, md[3:0]});
      @(negedge pclk);
      chk({31'h0, marker_receiver_enable}, {31'h0, md[3]});
      apb(0, 12'h164, 0);
      chk(rd, {28'h0, md[3:0]});
      apb(0, 12'h160, 0);
      chk(rd, {31'h0, md[4]});
      style <= (i == 0) ? 2'h2 : 2'(i % 2);
      repeat (40) begin
        @(posedge pclk);
        if (!s_valid || s_ready) begin
          s_valid <= 1'b1;
          s_data <= 12'($urandom);
          s_marker <= 1'($urandom);
          s_cal_state <= 1'($urandom);
        end
      end
      if (i == 0) chk({31'h0, s_ready}, 32'h0);
      @(posedge pclk);
      s_valid <= 1'b0;
      style <= 2'h0;
      k = 0;
      while (q.size() > 0 && k < 200) begin
        @(posedge pclk);
        k++;
      end
      chk(q.size(), 0);
      apb(0, 12'h168, 0);
      chk(rd, {30'h0, (md[4] && md[2]) ? 2'h1 : (md[0] ? 2'h2 : 2'h0)});
      $display("test mode %0d done", i);
    end
    report_and_stop();
  end
endmodule // sample_lsb_timestamp_insert_tb

// ===== testbench/sltsi_link_model.sv
/* Link-side sink model driving m_ready.
 Assumes the bench picks the stall style. */
module sltsi_link_model (
  input wire logic clk,
  input wire logic [1:0] style,
  output logic m_ready
);
  // ====
  // Style 0 prompt, 1 random stalls, 2 full stall
  initial m_ready = 1'b0;
  always @(posedge clk)
    m_ready <= (style == 2'h0) || (style == 2'h1 && $urandom % 2 == 0);
endmodule // sltsi_link_model

// ===== testbench/sltsi_top_properties.sv
/* Port checker for sltsi_top.
 Assumes one pclk domain. */
module sltsi_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic s_valid,
  input wire logic s_ready,
  input wire logic m_valid,
  input wire logic m_ready,
  input wire logic [sltsi_pkg::SLTSI_SAMPLE_W-1:0] m_data,
  input wire logic [3:0] ila_cs,
  input wire logic marker_receiver_enable
);
  // ====
  // Properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  sequence stall_s; m_valid && !m_ready; endsequence
  ila_zero_a: assert property (ila_cs == 4'h0) else $error("cs nonzero");
  out_hold_a: assert property (stall_s |=> m_valid && $stable(m_data))
    else $error("output moved");
  pass_lat_a: assert property (s_valid && s_ready && !m_valid |-> ##[1:2] m_valid)
    else $error("sample late");
  full_cause_a: assert property ($fell(s_ready) |-> $past(s_valid))
    else $error("refused idle");
  ctrl_width_a: assert property (acc && paddr == 12'h160 |-> prdata[31:8] == 24'h0)
    else $error("ctrl wide");
  ctrl_map_a: assert property (acc && paddr == 12'h160 |-> !pslverr)
    else $error("ctrl refused");
  bad_addr_a: assert property (acc && paddr == 12'h000 |-> pslverr)
    else $error("hole accepted");
  recv_src_a: assert property ($changed(marker_receiver_enable)
    |-> $past(acc && pwrite && paddr == 12'h164)) else $error("recv moved");
endmodule // sltsi_checker
bind sltsi_top sltsi_checker i_sltsi_checker (.*);
